/* common/cmp_pkg.sv */
// constants for the compare, branch and skip decode unit
package cmp_pkg;
    // opcode upper byte values (bits 23:16)
    localparam logic [7:0] OPC_GT_LT = 8'hE6;
    localparam logic [7:0] OPC_NE_EQ = 8'hE7;
    // field positions inside the 24-bit instruction word
    localparam int SEL_BIT   = 15;
    localparam int BASE_HI   = 14;
    localparam int BASE_LO   = 11;
    localparam int WIDTH_BIT = 10;
    localparam int OFS_HI    = 9;
    localparam int OFS_LO    = 4;
    localparam int SUB_HI    = 7;
    localparam int SUB_LO    = 4;
    localparam int SEC_HI    = 3;
    localparam int SEC_LO    = 0;
    // skip-form low subfield codes
    localparam logic [3:0] SUB_SKIP_A = 4'h0;
    localparam logic [3:0] SUB_SKIP_B = 4'h1;
    localparam logic [1:0] SKIP_PAD   = 2'h0;
    // width bit meaning
    localparam logic WIDTH_WORD = 1'b0;
    localparam logic WIDTH_BYTE = 1'b1;
    // cycle counts and PC step
    localparam logic [2:0] BRANCH_CYCLES  = 3'h5;
    localparam logic [2:0] SKIP1_CYCLES   = 3'h2;
    localparam logic [2:0] SKIP2_CYCLES   = 3'h3;
    localparam logic [15:0] PC_STEP       = 16'h0002;
    // instruction executed in place of a discarded one
    localparam logic [23:0] NOP_WORD      = 24'h000000;
endpackage

/* common/cmp_if.sv */
// operand comparison carrier between decode and comparator
interface cmp_if;
    logic [15:0] base_val;
    logic [15:0] sec_val;
    logic        byte_mode;
    logic        gt;
    logic        lt;
    logic        eq;
    modport ctl (output base_val, output sec_val, output byte_mode,
                 input gt, input lt, input eq);
    modport cmp (input base_val, input sec_val, input byte_mode,
                 output gt, output lt, output eq);
endinterface

/* rtl/operand_compare.sv */
// signed compare of two operands in byte or word width
module operand_compare (
    // operand channel
    cmp_if.cmp c
);
    logic signed [15:0] a_ext; // base operand, width adjusted
    logic signed [15:0] b_ext; // second operand, width adjusted
    logic signed [16:0] diff;  // base minus second, never overflows

    // byte mode sign-extends low eight bits
    always_comb begin
        if (c.byte_mode == cmp_pkg::WIDTH_BYTE) begin
            a_ext = {{8{c.base_val[7]}}, c.base_val[7:0]};
            b_ext = {{8{c.sec_val[7]}}, c.sec_val[7:0]};
        end else begin
            a_ext = c.base_val;
            b_ext = c.sec_val;
        end
        // 17 bits so the sign is exact; no flags are produced
        diff = {a_ext[15], a_ext} - {b_ext[15], b_ext};
        c.gt = !diff[16] && (diff != 17'h00000);
        c.lt = diff[16];
        c.eq = (diff == 17'h00000);
    end
endmodule

/* rtl/compare_branch_skip_unit.sv */
// decode and execute for register compare-and-branch and compare-and-skip
// Behaviour
// - greater branch: signed base minus second, flags kept
// - greater branch decode: E6, select bit zero
// - less branch: branch only when base is less
// - less branch decode: E6, select bit one
// - not-equal branch decode E7 bit zero, differ
// - equal skip variant A: E7, one, subfield zero
// - equal skip variant B: subfield 0001 instead
// - greater skip: E6, zero, subfield 0000
// - taken branch: PC+2+2*offset, NOP, five cycles
// - skip: one cycle, else two or three
// - width bit clear word, set byte
module compare_branch_skip_unit #(
    parameter bit EQ_SKIP_VARIANT_B = 1'b0 // selects equal-skip subfield
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // instruction issue from fetch
    input  wire logic        instr_valid,
    input  wire logic [23:0] instr_word,
    input  wire logic [15:0] instr_pc,
    input  wire logic        next_is_two_word,
    // register file read data
    input  wire logic [15:0] base_data,
    input  wire logic [15:0] sec_data,
    // register file read addresses
    output logic      [3:0]  base_addr,
    output logic      [3:0]  sec_addr,
    // program counter and pipeline control
    output logic             pc_load,
    output logic      [15:0] pc_target,
    output logic             flush_prefetch,
    output logic             nop_insert,
    output logic             busy,
    output logic             handled
);
    // execution states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STALL = 3'b010,
        ST_DONE  = 3'b100
    } exec_e;

    cmp_if cbus ();

    exec_e       state_ff,  nxt_state;
    logic [2:0]  cnt_ff,    nxt_cnt;     // remaining extra cycles
    logic        pc_load_ff, nxt_pc_load;
    logic [15:0] tgt_ff,    nxt_tgt;
    logic        flush_ff,  nxt_flush;
    logic        nop_ff,    nxt_nop;
    logic        busy_ff,   nxt_busy;
    logic        hand_ff,   nxt_hand;
    logic [3:0]  ba_ff,     nxt_ba;
    logic [3:0]  sa_ff,     nxt_sa;

    // decoded instruction kinds
    logic        is_gt_br, is_lt_br, is_ne_br, is_eq_sk, is_gt_sk;
    logic        any_br, any_sk, take;
    logic [7:0]  opc;
    logic [3:0]  sub;
    logic [15:0] ofs_x2;

    operand_compare u_cmp (
        .c (cbus.cmp)
    );

    // operand fields to comparator; register file supplies data combinationally
    assign cbus.base_val  = base_data;
    assign cbus.sec_val   = sec_data;
    assign cbus.byte_mode = instr_word[cmp_pkg::WIDTH_BIT];

    // opcode decode; skip forms checked first since branch layout overlaps
    always_comb begin
        opc = instr_word[23:16];
        sub = instr_word[cmp_pkg::SUB_HI:cmp_pkg::SUB_LO];
        is_gt_sk = instr_valid && opc == cmp_pkg::OPC_GT_LT
            && !instr_word[cmp_pkg::SEL_BIT]
            && instr_word[9:8] == cmp_pkg::SKIP_PAD
            && sub == cmp_pkg::SUB_SKIP_A;
        is_eq_sk = instr_valid && opc == cmp_pkg::OPC_NE_EQ
            && instr_word[cmp_pkg::SEL_BIT]
            && instr_word[9:8] == cmp_pkg::SKIP_PAD
            && sub == (EQ_SKIP_VARIANT_B ? cmp_pkg::SUB_SKIP_B
                                         : cmp_pkg::SUB_SKIP_A);
        // greater skip shares the greater-branch pattern with zero offset
        is_gt_br = instr_valid && opc == cmp_pkg::OPC_GT_LT
            && !instr_word[cmp_pkg::SEL_BIT] && !is_gt_sk;
        is_lt_br = instr_valid && opc == cmp_pkg::OPC_GT_LT
            && instr_word[cmp_pkg::SEL_BIT];
        is_ne_br = instr_valid && opc == cmp_pkg::OPC_NE_EQ
            && !instr_word[cmp_pkg::SEL_BIT];
        any_br = is_gt_br || is_lt_br || is_ne_br;
        any_sk = is_gt_sk || is_eq_sk;
        take = (is_gt_br && cbus.gt) || (is_lt_br && cbus.lt)
            || (is_ne_br && !cbus.eq)
            || (is_gt_sk && cbus.gt) || (is_eq_sk && cbus.eq);
        // signed six-bit offset doubled to a byte distance
        ofs_x2 = {{9{instr_word[cmp_pkg::OFS_HI]}},
                  instr_word[cmp_pkg::OFS_HI:cmp_pkg::OFS_LO], 1'b0};
    end

    // next-state and output computation
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_pc_load = 1'b0;
        nxt_tgt     = tgt_ff;
        nxt_flush   = 1'b0;
        nxt_nop     = 1'b0;
        nxt_busy    = busy_ff;
        nxt_hand    = 1'b0;
        nxt_ba      = instr_word[cmp_pkg::BASE_HI:cmp_pkg::BASE_LO];
        nxt_sa      = instr_word[cmp_pkg::SEC_HI:cmp_pkg::SEC_LO];
        case (state_ff)
            ST_IDLE: begin
                nxt_busy = 1'b0;
                if (any_br || any_sk) begin
                    nxt_hand = 1'b1;
                    if (take) begin
                        // discard prefetch and replace with NOP
                        nxt_flush = 1'b1;
                        nxt_nop   = 1'b1;
                        nxt_busy  = 1'b1;
                        nxt_state = ST_STALL;
                        if (any_br) begin
                            nxt_pc_load = 1'b1;
                            nxt_tgt = instr_pc + cmp_pkg::PC_STEP + ofs_x2;
                            nxt_cnt = cmp_pkg::BRANCH_CYCLES - 3'h2;
                        end else begin
                            // two-word victim costs one more NOP cycle
                            nxt_cnt = (next_is_two_word ? cmp_pkg::SKIP2_CYCLES
                                                        : cmp_pkg::SKIP1_CYCLES)
                                      - 3'h2;
                        end
                    end
                end
            end
            ST_STALL: begin
                // each extra cycle executes a NOP
                nxt_nop = 1'b1;
                if (cnt_ff == 3'h0) begin
                    nxt_nop   = 1'b0;
                    nxt_busy  = 1'b0;
                    nxt_state = ST_DONE;
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            ST_DONE: begin
                nxt_busy  = 1'b0;
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 3'h0;
            pc_load_ff <= 1'b0;
            tgt_ff     <= 16'h0000;
            flush_ff   <= 1'b0;
            nop_ff     <= 1'b0;
            busy_ff    <= 1'b0;
            hand_ff    <= 1'b0;
            ba_ff      <= 4'h0;
            sa_ff      <= 4'h0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            pc_load_ff <= nxt_pc_load;
            tgt_ff     <= nxt_tgt;
            flush_ff   <= nxt_flush;
            nop_ff     <= nxt_nop;
            busy_ff    <= nxt_busy;
            hand_ff    <= nxt_hand;
            ba_ff      <= nxt_ba;
            sa_ff      <= nxt_sa;
        end
    end

    assign pc_load        = pc_load_ff;
    assign pc_target      = tgt_ff;
    assign flush_prefetch = flush_ff;
    assign nop_insert     = nop_ff;
    assign busy           = busy_ff;
    assign handled        = hand_ff;
    assign base_addr      = ba_ff;
    assign sec_addr       = sa_ff;

    // helper: nop cycles counted since a flush
    logic [2:0] nop_run_ff;  // length of the current nop run
    logic [2:0] nxt_nop_run; // next run length

    // run length next value; no saturation, a run longer than four is itself the fault
    always_comb begin
        if (flush_ff) begin
            nxt_nop_run = 3'h1; // a flush opens a new run
        end else if (nop_ff) begin
            nxt_nop_run = nop_run_ff + 3'h1;
        end else begin
            nxt_nop_run = 3'h0; // issue resumed
        end
    end

    // run length register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nop_run_ff <= 3'h0;
        end else begin
            nop_run_ff <= nxt_nop_run;
        end
    end

    branch_target_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && any_br && take) |=>
        pc_load && pc_target == $past(instr_pc) + 16'h0002 + $past(ofs_x2))
        else $error("branch target wrong");
    branch_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && any_br && take) |=> nop_insert[*4] ##1 !nop_insert)
        else $error("branch stall length wrong");
    skip_short_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && any_sk && take && !next_is_two_word)
        |=> flush_prefetch ##1 !nop_insert)
        else $error("short skip length wrong");
    skip_long_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && any_sk && take && next_is_two_word)
        |=> nop_insert[*2] ##1 !nop_insert)
        else $error("long skip length wrong");
    not_taken_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && (any_br || any_sk) && !take)
        |=> !flush_prefetch && !pc_load && !busy)
        else $error("untaken compare stalled");
    gt_branch_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && is_gt_br && !cbus.gt) |=> !pc_load)
        else $error("greater branch taken wrongly");
    ne_branch_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && is_ne_br && base_data == sec_data) |=> !pc_load)
        else $error("not-equal branch on equal");
    skip_no_pc_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && any_sk) |=> !pc_load)
        else $error("skip loaded pc");
    nop_run_a: assert property (@(posedge clk) disable iff (sys_rst)
        nop_run_ff <= 3'h4)
        else $error("nop run too long");
endmodule

/* tb/test_compare_branch_skip_unit.sv */
// self-checking bench for the compare, branch and skip unit
module test_compare_branch_skip_unit;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus, all given a value at time zero
    logic        clk              = 1'b0;
    logic        sys_rst          = 1'b1;
    logic        instr_valid      = 1'b0;
    logic [23:0] instr_word       = 24'h000000;
    logic [15:0] instr_pc         = 16'h1000;
    logic        next_is_two_word = 1'b0;
    logic [15:0] base_data        = 16'h0000;
    logic [15:0] sec_data         = 16'h0000;
    // observed outputs, second set from the other equal-skip variant
    logic [3:0]  base_addr;
    logic [3:0]  sec_addr;
    logic [15:0] pc_target;
    logic        pc_load;
    logic        flush_prefetch;
    logic        nop_insert;
    logic        busy;
    logic        handled;
    logic        flush_b;
    logic        handled_b;
    // mismatch and comparison counters
    int          fail_count       = 0;
    int          n_checks         = 0;

    // 250 MHz core clock
    always #2 clk = ~clk;

    // variant with equal-skip subfield 0000
    compare_branch_skip_unit #(.EQ_SKIP_VARIANT_B(1'b0)) i_compare_branch_skip_unit (
        .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_pc(instr_pc), .next_is_two_word(next_is_two_word), .base_data(base_data),
        .sec_data(sec_data), .base_addr(base_addr), .sec_addr(sec_addr), .pc_load(pc_load),
        .pc_target(pc_target), .flush_prefetch(flush_prefetch), .nop_insert(nop_insert),
        .busy(busy), .handled(handled));
    // variant with equal-skip subfield 0001, same stimulus
    compare_branch_skip_unit #(.EQ_SKIP_VARIANT_B(1'b1)) i_compare_branch_skip_unit_b (
        .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_pc(instr_pc), .next_is_two_word(next_is_two_word), .base_data(base_data),
        .sec_data(sec_data), .base_addr(), .sec_addr(), .pc_load(), .pc_target(),
        .flush_prefetch(flush_b), .nop_insert(), .busy(), .handled(handled_b));

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // instruction word from its fields; mid is offset or {2'b00, subfield}
    function automatic logic [23:0] mk(input logic [7:0] op, input logic sel,
                                       input logic [3:0] breg, input logic wd,
                                       input logic [5:0] mid, input logic [3:0] ws);
        return {op, sel, breg, wd, mid, ws};
    endfunction

    // issue one word; kind 0 ignored, 1 not taken, 2 branch, 3 skip
    task automatic run(input logic [23:0] w, input logic [15:0] b, input logic [15:0] s,
                       input logic two, input int ka, input int kb);
        logic [15:0] tgt;
        int          nops;
        int          cyc;
        tgt  = 16'h1000 + cmp_pkg::PC_STEP + {{9{w[9]}}, w[9:4], 1'b0};
        nops = 0;
        cyc  = (ka == 2) ? 5 : (ka == 3) ? (two ? 3 : 2) : 1;
        @(posedge clk);
        instr_valid      <= 1'b1;
        instr_word       <= w;
        base_data        <= b;
        sec_data         <= s;
        next_is_two_word <= two;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        // answer checked 1 ns after the taking edge
        chk("handled", {15'h0, ka != 0}, {15'h0, handled});
        chk("pc_load", {15'h0, ka == 2}, {15'h0, pc_load});
        chk("flush", {15'h0, ka >= 2}, {15'h0, flush_prefetch});
        chk("busy", {15'h0, ka >= 2}, {15'h0, busy});
        chk("base_addr", {12'h0, w[14:11]}, {12'h0, base_addr});
        chk("sec_addr", {12'h0, w[3:0]}, {12'h0, sec_addr});
        chk("handled_b", {15'h0, kb != 0}, {15'h0, handled_b});
        chk("flush_b", {15'h0, kb >= 2}, {15'h0, flush_b});
        if (ka == 2) begin
            chk("pc_target", tgt, pc_target);
        end
        // count the inserted nop cycles, bounded
        while (nop_insert === 1'b1 && nops < 8) begin
            nops++;
            @(posedge clk);
            #1;
        end
        if (nops == 8) begin
            fail_count++;
            wrap_up();
        end
        chk("cycles", 16'(cyc), 16'(1 + nops));
        chk("busy end", 16'h0000, {15'h0, busy});
        // let both variants reach idle before the next word
        repeat (3) @(posedge clk);
    endtask

    // outputs quiet after reset, foreign opcode ignored
    task automatic t_reset();
        @(posedge clk);
        #1;
        chk("rst busy", 16'h0000, {15'h0, busy});
        chk("rst nop", 16'h0000, {15'h0, nop_insert});
        chk("rst handled", 16'h0000, {15'h0, handled});
        run(24'hE81234, 16'h0001, 16'h0000, 1'b0, 0, 0);
        $display("test reset done");
    endtask

    // signed greater branch, negative offset
    task automatic t_greater_branch();
        logic [23:0] w;
        w = mk(cmp_pkg::OPC_GT_LT, 1'b0, 4'h2, cmp_pkg::WIDTH_WORD, 6'h3E, 4'h3);
        run(w, 16'h0005, 16'hFFFE, 1'b0, 2, 2);
        run(w, 16'h8000, 16'h0001, 1'b0, 1, 1);
        run(w, 16'h0007, 16'h0007, 1'b0, 1, 1);
        $display("test greater branch done");
    endtask

    // signed less branch, largest positive offset
    task automatic t_less_branch();
        logic [23:0] w;
        w = mk(cmp_pkg::OPC_GT_LT, 1'b1, 4'h5, cmp_pkg::WIDTH_WORD, 6'h1F, 4'h6);
        run(w, 16'hFFF0, 16'h0003, 1'b0, 2, 2);
        run(w, 16'h0003, 16'h0003, 1'b0, 1, 1);
        $display("test less branch done");
    endtask

    // not-equal branch, most negative offset
    task automatic t_ne_branch();
        logic [23:0] w;
        w = mk(cmp_pkg::OPC_NE_EQ, 1'b0, 4'hF, cmp_pkg::WIDTH_WORD, 6'h20, 4'h0);
        run(w, 16'h1234, 16'h1235, 1'b0, 2, 2);
        run(w, 16'h1234, 16'h1234, 1'b0, 1, 1);
        $display("test not-equal branch done");
    endtask

    // equal skip in both subfield variants, cycle count checked only for the two-word skip of variant A
    task automatic t_equal_skip();
        logic [23:0] wa;
        logic [23:0] wsub;
        wa = mk(cmp_pkg::OPC_NE_EQ, 1'b1, 4'h1, cmp_pkg::WIDTH_WORD, 6'h00, 4'h8);
        wsub = mk(cmp_pkg::OPC_NE_EQ, 1'b1, 4'h1, cmp_pkg::WIDTH_WORD, 6'h01, 4'h8);
        run(wa, 16'h3344, 16'h3344, 1'b1, 3, 0);
        run(wa, 16'h3344, 16'h3345, 1'b1, 1, 0);
        run(wsub, 16'h3344, 16'h3344, 1'b0, 0, 3);
        run(wsub, 16'h0000, 16'h8000, 1'b0, 0, 1);
        $display("test equal skip done");
    endtask

    // signed greater skip
    task automatic t_greater_skip();
        logic [23:0] w;
        w = mk(cmp_pkg::OPC_GT_LT, 1'b0, 4'h0, cmp_pkg::WIDTH_WORD, 6'h00, 4'h1);
        run(w, 16'h0001, 16'hFFFF, 1'b0, 3, 3);
        run(w, 16'hFFFF, 16'h0001, 1'b1, 1, 1);
        $display("test greater skip done");
    endtask

    // byte width uses sign-extended low bytes only
    task automatic t_byte_mode();
        logic [23:0] w;
        w = mk(cmp_pkg::OPC_GT_LT, 1'b0, 4'h3, cmp_pkg::WIDTH_BYTE, 6'h04, 4'h9);
        run(w, 16'h017F, 16'h0280, 1'b0, 2, 2);
        w[cmp_pkg::WIDTH_BIT] = cmp_pkg::WIDTH_WORD;
        run(w, 16'h017F, 16'h0280, 1'b0, 1, 1);
        w = mk(cmp_pkg::OPC_GT_LT, 1'b1, 4'h3, cmp_pkg::WIDTH_BYTE, 6'h10, 4'h9);
        run(w, 16'h00FF, 16'h7F01, 1'b0, 2, 2);
        w = mk(cmp_pkg::OPC_NE_EQ, 1'b1, 4'h2, cmp_pkg::WIDTH_BYTE, 6'h00, 4'h4);
        run(w, 16'h1234, 16'h5634, 1'b0, 3, 0);
        $display("test byte mode done");
    endtask

    // main sequence: reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_greater_branch();
        t_less_branch();
        t_ne_branch();
        t_equal_skip();
        t_greater_skip();
        t_byte_mode();
        wrap_up();
    end
endmodule
